/* design/lcsd_lcd_driver.v */
// segment lcd controller: frame timing, ram scan and drive levels
// Contract
// [R1] boost with static duty: all four commons carry the same waveform
// [R2] boost with 1/2 duty: common_output_1 wave on pins 1,2; com2 on 3,4
// [R3] two-bit duty select picks static, 1/2, 1/3 or 1/4 duty
// [R4] only segment drivers enabled by segment select field are active
// [R5] frame rate derives from the four-bit frame clock select
// [R6] waveform select bit picks A-type or B-type alternation
// [R7] display ram takes byte or word reads and writes like normal ram
// [R8] display starts by itself once activated, no extra command
// [R9] expansion enable with segment select 0000 uses the expanded map
// [R10] in charge period the split resistance is connected
// [R11] discharge follows charge; the two repeat continuously
// [R12] charge duty field sets ratio of charge to discharge
// [R13] output level per data bit, alternation M and duty
// [R14] subclock-only modes display only with subclock sources
// [R15] software retunes frame select when entering medium speed
// [R16] standby stops display and turns drive power off
// [R17] module standby gates the clock and stops display
// [R18] clearing activate halts block and powers off, keeps registers
// [R19] charge duty encoding: always, n/8, never, 1/16, 1/32
// [R20] frame clock encoding: subclock /1 /2 /4, system clock /2../256
// [R21] display data control 0 blanks output, 1 shows ram data
`default_nettype none
`include "lcsd_map.vh"
module lcsd_lcd_driver
#(
  parameter NUM_SEG = `LCSD_NUM_SEG, // segment outputs
  parameter RAM_WORDS = 20, // 16-bit words of display ram
  parameter AW = 5 // word address width
)
(
  input wire clk_sys, // system clock
  input wire rst_n, // async reset, active low
  input wire subclk_in, // subclock from pin, asynchronous
  input wire sysclk_run, // system clock source running
  input wire standby_mode, // standby power-down mode
  input wire module_standby, // module clock gated off
  input wire display_activate, // block operates
  input wire drive_power_switch, // drive power requested
  input wire display_data_control, // 1 show ram, 0 blank
  input wire [3:0] frame_clock_select, // frame clock source
  input wire duty_select_hi, // duty select msb
  input wire duty_select_lo, // duty select lsb
  input wire common_output_boost, // common drive boost
  input wire segment_expansion_enable, // external expansion map
  input wire [3:0] segment_select, // enabled segment groups
  input wire waveform_type_select, // 0 A wave, 1 B wave
  input wire [3:0] charge_duty_select, // charge duty
  input wire ram_req, // cpu ram access strobe
  input wire ram_we, // write when high
  input wire ram_word, // word access when high
  input wire [AW:0] ram_addr, // byte address
  input wire [15:0] ram_wdata, // write data
  output reg [15:0] ram_rdata, // read data
  output wire ram_ack, // access done, same cycle
  output reg [7:0] com_level, // 2 bits per common pin
  output reg [2*NUM_SEG-1:0] seg_level, // 2 bits per segment pin
  output reg [NUM_SEG-1:0] seg_enable, // segment driver on
  output reg alt_m, // alternation signal M
  output reg drive_power_on, // drive rail supply on
  output wire split_connect, // split resistance connected
  output reg display_running // scanning active
);
  ////////////////////////////////////////////////////////////////
  // display ram, byte addressed, little endian within a word
  reg [15:0] ram [0:RAM_WORDS-1];
  wire [AW-1:0] widx = ram_addr[AW:1];
  assign ram_ack = ram_req; // [R7]
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ram_rdata <= 16'h0000;
    else if (ram_req && !ram_we && widx < RAM_WORDS)
    begin
      if (ram_word)
        ram_rdata <= ram[widx]; // [R7]
      else if (ram_addr[0])
        ram_rdata <= {8'h00, ram[widx][15:8]}; // [R7]
      else
        ram_rdata <= {8'h00, ram[widx][7:0]}; // [R7]
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < RAM_WORDS; gi = gi + 1)
    begin : g_ram
      always @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          ram[gi] <= 16'h0000;
        else if (ram_req && ram_we && widx == gi)
        begin
          if (ram_word || !ram_addr[0])
            ram[gi][7:0] <= ram_wdata[7:0]; // [R7]
          if (ram_word)
            ram[gi][15:8] <= ram_wdata[15:8]; // [R7]
          else if (ram_addr[0])
            ram[gi][15:8] <= ram_wdata[7:0]; // [R7]
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  // subclock synchroniser and edge detect
  reg sub_s1, sub_s2, sub_s3;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end
    else
    begin
      sub_s1 <= subclk_in;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end
  wire sub_edge = sub_s2 & ~sub_s3;
  ////////////////////////////////////////////////////////////////
  // run gating: activate, standby and module standby all stop scan
  wire use_sys = frame_clock_select[3];
  wire src_ok = use_sys ? sysclk_run : 1'b1; // [R14]
  wire run = display_activate & ~standby_mode & ~module_standby
    & src_ok; // [R8] [R16] [R17] [R18]
  ////////////////////////////////////////////////////////////////
  // frame clock divider, one-cycle step pulse out
  reg [`LCSD_SYS_DIV_W-1:0] div_cnt;
  reg [4:0] div_log2;
  reg step;
  always @*
  begin
    if (use_sys)
      div_log2 = {2'h0, frame_clock_select[2:0]} + 5'h01; // [R20]
    else if (frame_clock_select[1])
      div_log2 = 5'h02; // [R20]
    else
      div_log2 = {4'h0, frame_clock_select[0]}; // [R20]
  end
  wire div_tick = use_sys ? 1'b1 : sub_edge; // [R5]
  wire [`LCSD_SYS_DIV_W-1:0] div_top =
    (`LCSD_SYS_DIV_W'h1 << div_log2) - `LCSD_SYS_DIV_W'h1;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= {`LCSD_SYS_DIV_W{1'b0}};
      step <= 1'b0;
    end
    else if (!run)
    begin
      div_cnt <= {`LCSD_SYS_DIV_W{1'b0}};
      step <= 1'b0;
    end
    else
    begin
      step <= 1'b0;
      if (div_tick)
      begin
        if (div_cnt >= div_top)
        begin
          div_cnt <= {`LCSD_SYS_DIV_W{1'b0}};
          step <= 1'b1; // [R5]
        end
        else
          div_cnt <= div_cnt + `LCSD_SYS_DIV_W'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // common scan and alternation
  wire [1:0] duty = {duty_select_hi, duty_select_lo}; // [R3]
  reg [1:0] com_idx;
  wire [1:0] com_last = duty; // static 0, 1/2 1, 1/3 2, 1/4 3
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      com_idx <= 2'h0;
      alt_m <= 1'b0;
      display_running <= 1'b0;
    end
    else if (!run)
    begin
      com_idx <= 2'h0;
      alt_m <= 1'b0; // [R18]
      display_running <= 1'b0;
    end
    else
    begin
      display_running <= 1'b1; // [R8]
      if (step)
      begin
        if (waveform_type_select)
        begin
          // B wave flips M once per frame
          if (com_idx >= com_last)
          begin
            com_idx <= 2'h0;
            alt_m <= ~alt_m; // [R6]
          end
          else
            com_idx <= com_idx + 2'h1;
        end
        else
        begin
          // A wave flips M each step, advances common on M=1
          alt_m <= ~alt_m; // [R6]
          if (alt_m)
            com_idx <= (com_idx >= com_last) ? 2'h0 : com_idx + 2'h1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // output levels
  function [1:0] com_lv;
    input sel;
    input m;
    input [1:0] d;
    begin
      if (sel)
        com_lv = m ? `LCSD_LVL_VSS : `LCSD_LVL_V1; // [R13]
      else if (d == `LCSD_DUTY_STATIC)
        com_lv = m ? `LCSD_LVL_VSS : `LCSD_LVL_V1; // [R13]
      else if (d == `LCSD_DUTY_HALF)
        com_lv = `LCSD_LVL_V2; // [R13]
      else
        com_lv = m ? `LCSD_LVL_V2 : `LCSD_LVL_V3; // [R13]
    end
  endfunction
  function [1:0] seg_lv;
    input on;
    input m;
    input [1:0] d;
    begin
      if (on)
        seg_lv = m ? `LCSD_LVL_V1 : `LCSD_LVL_VSS; // [R13]
      else if (d == `LCSD_DUTY_STATIC || d == `LCSD_DUTY_HALF)
        seg_lv = m ? `LCSD_LVL_VSS : `LCSD_LVL_V1; // [R13]
      else
        seg_lv = m ? `LCSD_LVL_V3 : `LCSD_LVL_V2; // [R13]
    end
  endfunction
  // expanded map: expansion enable together with segment_select 0000;
  // on-chip segment drivers then stay disabled
  wire expanded = segment_expansion_enable &&
    (segment_select == 4'h0); // [R9]
  reg [7:0] next_com;
  integer ci;
  always @*
  begin
    next_com = 8'h00;
    for (ci = 0; ci < `LCSD_NUM_COM; ci = ci + 1)
    begin
      if (common_output_boost && duty == `LCSD_DUTY_STATIC)
        next_com[2*ci +: 2] = com_lv(1'b1, alt_m, duty); // [R1]
      else if (common_output_boost && duty == `LCSD_DUTY_HALF)
        next_com[2*ci +: 2] = com_lv(com_idx == ci[2:1], alt_m,
          duty); // [R2]
      else if (ci[1:0] > com_last)
        next_com[2*ci +: 2] = com_lv(1'b0, alt_m, duty);
      else
        next_com[2*ci +: 2] = com_lv(com_idx == ci[1:0], alt_m, duty);
    end
  end
  // segment s, common c: byte s/2, nibble s%2, bit c
  generate
    for (gi = 0; gi < NUM_SEG; gi = gi + 1)
    begin : g_seg
      wire [15:0] w = ram[gi / 4];
      wire [3:0] nib = w[4 * (gi % 4) +: 4];
      wire bit_on = nib[com_idx] & display_data_control; // [R21]
      wire en = !expanded &&
        ((gi / `LCSD_SEG_GROUP) < {segment_select, 1'b0}); // [R4]
      always @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          seg_level[2*gi +: 2] <= `LCSD_LVL_VSS;
          seg_enable[gi] <= 1'b0;
        end
        else if (!run)
        begin
          seg_level[2*gi +: 2] <= `LCSD_LVL_VSS; // [R17]
          seg_enable[gi] <= 1'b0;
        end
        else
        begin
          seg_level[2*gi +: 2] <= seg_lv(bit_on, alt_m, duty); // [R13]
          seg_enable[gi] <= en & (segment_select != 4'h0); // [R4]
        end
      end
    end
  endgenerate
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      com_level <= 8'h00;
      drive_power_on <= 1'b0;
    end
    else
    begin
      com_level <= run ? next_com : 8'h00; // [R16]
      drive_power_on <= run & drive_power_switch; // [R16] [R18]
    end
  end
  ////////////////////////////////////////////////////////////////
  lcsd_charge_gen u_charge
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(run & drive_power_switch),
    .step(step),
    .charge_duty_select(charge_duty_select),
    .charge_period(split_connect)
  );
endmodule
`default_nettype wire

/* inc/lcsd_map.vh */
// constants for the segment lcd scan and drive block
`ifndef LCSD_MAP_VH
`define LCSD_MAP_VH
`define LCSD_DUTY_STATIC 2'h0
`define LCSD_DUTY_HALF 2'h1
`define LCSD_DUTY_THIRD 2'h2
`define LCSD_DUTY_QUARTER 2'h3
`define LCSD_LVL_VSS 2'h0
`define LCSD_LVL_V3 2'h1
`define LCSD_LVL_V2 2'h2
`define LCSD_LVL_V1 2'h3
`define LCSD_CDS_ALWAYS 4'h0
`define LCSD_CDS_NEVER 4'h7
`define LCSD_CHG_STEPS 5'h1F
`define LCSD_SEG_GROUP 4
`define LCSD_NUM_SEG 40
`define LCSD_NUM_COM 4
`define LCSD_SUB_DIV_W 8
`define LCSD_SUB_DIV_W_W 5'h08
`define LCSD_SYS_DIV_W 8
`define LCSD_SYS_DIV_W_W 5'h08
`endif

/* design/lcsd_charge_gen.v */
// charge and discharge pulse generator for the drive rail capacitors
`default_nettype none
module lcsd_charge_gen
(
  input wire clk_sys, // system clock
  input wire rst_n, // async reset, active low
  input wire run, // block active
  input wire step, // one pulse per charge step
  input wire [3:0] charge_duty_select, // charge to discharge ratio
  output reg charge_period // split resistance connected
);
`include "lcsd_map.vh"
  reg [4:0] phase;
  reg [4:0] limit;
  reg next_charge;
  ////////////////////////////////////////////////////////////////
  // phase counter wraps every 8, 16 or 32 steps
  always @*
  begin
    limit = 5'h07;
    if (charge_duty_select[3])
      limit = charge_duty_select[2] ? 5'h1F : 5'h0F; // [R19]
  end
  always @*
  begin
    next_charge = 1'b0;
    if (charge_duty_select == `LCSD_CDS_ALWAYS)
      next_charge = 1'b1; // [R19]
    else if (charge_duty_select == `LCSD_CDS_NEVER)
      next_charge = 1'b0; // [R19]
    else if (charge_duty_select[3])
      next_charge = (phase == 5'h00); // [R12]
    else
      next_charge = (phase < {2'h0, charge_duty_select[2:0]}); // [R12]
  end
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= 5'h00;
      charge_period <= 1'b0;
    end
    else if (!run)
    begin
      phase <= 5'h00;
      charge_period <= 1'b0;
    end
    else
    begin
      if (step)
        phase <= (phase >= limit) ? 5'h00 : phase + 5'h01; // [R11]
      charge_period <= next_charge; // [R10]
    end
  end
endmodule
`default_nettype wire

/* sim/lcsd_checker.sv */
// port assertions for the segment lcd driver
`default_nettype none
`include "lcsd_map.vh"
module lcsd_checker #(parameter NUM_SEG = 40)
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic sysclk_run, // system clock up
  input wire logic [3:0] frame_clock_select, // frame source
  input wire logic standby_mode, // standby
  input wire logic module_standby, // gated
  input wire logic display_activate, // act
  input wire logic drive_power_switch, // psw
  input wire logic duty_select_hi, // duty msb
  input wire logic duty_select_lo, // duty lsb
  input wire logic common_output_boost, // boost
  input wire logic segment_expansion_enable, // expansion
  input wire logic [3:0] segment_select, // groups
  input wire logic [3:0] charge_duty_select, // charge duty
  input wire logic [7:0] com_level, // commons
  input wire logic [NUM_SEG-1:0] seg_enable, // drivers
  input wire logic alt_m, // m
  input wire logic drive_power_on, // power
  input wire logic split_connect, // split
  input wire logic display_running // running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run;
  logic [1:0] duty;
  logic [NUM_SEG-1:0] exp_en;
  // a system clock source needs the system clock running
  assign run = display_activate && !standby_mode && !module_standby &&
    (!frame_clock_select[3] || sysclk_run);
  assign duty = {duty_select_hi, duty_select_lo};
  // groups of eight per code step, clipped at the pin count
  always_comb
    exp_en = (segment_select * 8 >= NUM_SEG) ? '1 :
      (NUM_SEG'(1) << (segment_select * 8)) - 1'b1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////
  property p_run;
    run |=> display_running;
  endproperty
  a_run: assert property (p_run) else $error("no start");
  property p_stop;
    !run |=> !display_running;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_pwr;
    (!display_activate || standby_mode) |=> !drive_power_on;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power on");
  property p_never;
    $past(charge_duty_select) == 4'h7 |-> !split_connect;
  endproperty
  a_never: assert property (p_never) else $error("split on");
  property p_always;
    (run && drive_power_switch && charge_duty_select == 4'h0)[*3]
      |-> split_connect;
  endproperty
  a_always: assert property (p_always) else $error("split off");
  property p_bst_s;
    (run && common_output_boost && duty == `LCSD_DUTY_STATIC)[*3]
      |-> com_level == {4{com_level[1:0]}};
  endproperty
  a_bst_s: assert property (p_bst_s) else $error("boost static");
  property p_bst_h;
    (run && common_output_boost && duty == `LCSD_DUTY_HALF)[*3]
      |-> com_level[3:2] == com_level[1:0] && com_level[7:6] == com_level[5:4];
  endproperty
  a_bst_h: assert property (p_bst_h) else $error("boost half");
  property p_scom;
    (run && duty == `LCSD_DUTY_STATIC)[*3]
      |-> com_level[1:0] == ($past(alt_m) ? `LCSD_LVL_VSS : `LCSD_LVL_V1);
  endproperty
  a_scom: assert property (p_scom) else $error("static common");
  property p_mask;
    (run && !segment_expansion_enable && $stable(segment_select))[*3]
      |-> seg_enable == exp_en;
  endproperty
  a_mask: assert property (p_mask) else $error("seg mask");
  property p_exp;
    (run && segment_expansion_enable)[*3] |-> seg_enable == '0;
  endproperty
  a_exp: assert property (p_exp) else $error("expanded on");
endmodule
`default_nettype wire

/* sim/lcsd_panel_model.sv */
// lcd panel model: counts cycles where cell seg0/common_output_1 sees full swing
`default_nettype none
module lcsd_panel_model
(
  input wire logic clk_sys, // clock
  input wire logic [7:0] com_level, // common levels
  input wire logic [79:0] seg_level, // segment levels
  input wire logic [39:0] seg_enable, // drivers on
  output var int lit_cycles // lit count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lit_cycles = 0;
  // only v1 against vss lights; v2/v3 pairs stay dark
  always @(posedge clk_sys)
    if (seg_enable[0] && ({com_level[1:0], seg_level[1:0]} == 4'hC ||
        {com_level[1:0], seg_level[1:0]} == 4'h3))
      lit_cycles <= lit_cycles + 1;
endmodule
`default_nettype wire

/* sim/lcsd_lcd_driver_tb_top.sv */
// testbench top for the segment lcd driver
`default_nettype none
module lcsd_lcd_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, sysclk_run, standby_mode, module_standby;
  logic display_activate, drive_power_switch, display_data_control;
  logic duty_select_hi, duty_select_lo, common_output_boost;
  logic segment_expansion_enable, waveform_type_select;
  logic ram_req, ram_we, ram_word, ram_ack, alt_m;
  logic drive_power_on, split_connect, display_running;
  logic [3:0] frame_clock_select, segment_select, charge_duty_select, sub_cnt;
  logic [5:0] ram_addr;
  logic [15:0] ram_wdata, ram_rdata;
  logic [7:0] com_level;
  logic [79:0] seg_level;
  logic [39:0] seg_enable;
  wire logic subclk_in;
  int failures, checks_done, lit_cycles, mc, sc, v;
  assign subclk_in = sub_cnt[3];
  lcsd_lcd_driver uut
  (
    .clk_sys, .rst_n, .subclk_in, .sysclk_run, .standby_mode,
    .module_standby, .display_activate, .drive_power_switch,
    .display_data_control, .frame_clock_select, .duty_select_hi,
    .duty_select_lo, .common_output_boost, .segment_expansion_enable,
    .segment_select, .waveform_type_select, .charge_duty_select,
    .ram_req, .ram_we, .ram_word, .ram_addr, .ram_wdata, .ram_rdata,
    .ram_ack, .com_level, .seg_level, .seg_enable, .alt_m,
    .drive_power_on, .split_connect, .display_running
  );
  lcsd_panel_model panel (.clk_sys, .com_level, .seg_level, .seg_enable,
    .lit_cycles);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) sub_cnt <= sub_cnt + 4'h1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic ram_go(input logic we, w, input logic [5:0] a,
    input logic [15:0] d);
    ram_req <= 1'h1;
    ram_we <= we;
    ram_word <= w;
    ram_addr <= a;
    ram_wdata <= d;
    tick(1);
    check(ram_ack, 32'h1);
    ram_req <= 1'h0;
    tick(1);
  endtask
  task automatic watch(input int n);
    logic pm;
    mc = 0;
    sc = 0;
    pm = alt_m;
    repeat (n)
    begin
      @(posedge clk_sys);
      mc += (alt_m !== pm);
      sc += split_connect;
      pm = alt_m;
    end
  endtask
  function automatic int chg(input int c);
    return c == 0 ? 256 : c < 7 ? c * 32 : c == 7 ? 0 : c < 12 ? 16 : 8;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk_sys, rst_n, standby_mode, module_standby, ram_req, ram_we} = '0;
    {display_activate, drive_power_switch, display_data_control} = '0;
    {duty_select_hi, duty_select_lo, common_output_boost} = '0;
    {segment_expansion_enable, waveform_type_select, ram_word} = '0;
    {ram_addr, ram_wdata, frame_clock_select, segment_select} = '0;
    {charge_duty_select, sub_cnt} = '0;
    sysclk_run = 1'h1;
    tick(3);
    rst_n <= 1'h1;
    tick(1);
    check({display_running, drive_power_on, split_connect}, 32'h0);
    ram_go(1, 1, 6'h02, 16'hA5C3);
    ram_go(0, 0, 6'h03, 16'h0000);
    check(ram_rdata[7:0], 32'hA5);
    ram_go(1, 0, 6'h02, 16'h007E);
    ram_go(0, 1, 6'h02, 16'h0000);
    check(ram_rdata, 32'hA57E);
    ram_go(0, 1, 6'h28, 16'h0000);
    check(ram_rdata, 32'hA57E);
    ram_go(1, 1, 6'h00, 16'h0001);
    $display("ram test done");
    display_activate <= 1'h1;
    display_data_control <= 1'h1;
    drive_power_switch <= 1'h1;
    frame_clock_select <= 4'h8;
    segment_select <= 4'h5;
    tick(3);
    check({display_running, drive_power_on, split_connect}, 32'h7);
    watch(64);
    check(lit_cycles != 0, 32'h1);
    display_data_control <= 1'h0;
    tick(4);
    v = lit_cycles;
    watch(64);
    check(lit_cycles, v);
    for (int c = 0; c < 16; c++)
    begin
      charge_duty_select <= c[3:0];
      tick(40);
      watch(256);
      check(sc, chg(c));
    end
    $display("charge test done");
    {duty_select_hi, duty_select_lo} <= 2'h3;
    for (int k = 8; k < 16; k++)
    begin
      frame_clock_select <= k[3:0];
      tick(300);
      watch(512);
      check(mc, 512 >> (k - 7));
    end
    frame_clock_select <= 4'h8;
    waveform_type_select <= 1'h1;
    tick(40);
    watch(128);
    check(mc, 32'h10);
    // sub-only mode: only subclock sources keep the display running
    waveform_type_select <= 1'h0;
    sysclk_run <= 1'h0;
    for (int c = 0; c < 4; c++)
    begin
      frame_clock_select <= c[3:0];
      tick(100);
      watch(512);
      check(mc, 32 >> (c > 1 ? 2 : c));
    end
    frame_clock_select <= 4'h8;
    tick(3);
    check({display_running, drive_power_on}, 32'h0);
    sysclk_run <= 1'h1;
    $display("frame test done");
    common_output_boost <= 1'h1;
    for (int d = 0; d < 4; d++)
    begin
      {duty_select_hi, duty_select_lo} <= d[1:0];
      tick(40);
    end
    common_output_boost <= 1'h0;
    for (int s = 0; s < 7; s++)
    begin
      segment_select <= s[3:0];
      tick(5);
    end
    segment_expansion_enable <= 1'h1;
    segment_select <= 4'h0;
    tick(5);
    check(|seg_enable, 32'h0);
    segment_expansion_enable <= 1'h0;
    module_standby <= 1'h1;
    tick(3);
    check(display_running, 32'h0);
    module_standby <= 1'h0;
    standby_mode <= 1'h1;
    tick(3);
    check({display_running, drive_power_on}, 32'h0);
    standby_mode <= 1'h0;
    display_activate <= 1'h0;
    tick(3);
    check({display_running, drive_power_on}, 32'h0);
    ram_go(0, 1, 6'h02, 16'h0000);
    check(ram_rdata, 32'hA57E);
    $display("power test done");
    close_out;
  end
  initial
  begin
    #120000;
    failures++;
    close_out;
  end
endmodule
bind lcsd_lcd_driver lcsd_checker #(.NUM_SEG(NUM_SEG)) chk
(
  .clk_sys, .rst_n, .sysclk_run, .frame_clock_select, .standby_mode,
  .module_standby, .display_activate, .drive_power_switch,
  .duty_select_hi, .duty_select_lo, .common_output_boost,
  .segment_expansion_enable, .segment_select, .charge_duty_select,
  .com_level, .seg_enable, .alt_m, .drive_power_on, .split_connect,
  .display_running
);
`default_nettype wire
